// [nsd_defines.svh]
`ifndef NSD_DEFINES_SVH
`define NSD_DEFINES_SVH

// ---------------------------------------------------------------
// Opcode fields
// ---------------------------------------------------------------
`define NSD_SWAP_HI        6'h0e
`define NSD_SWAP_HI_MSB    13
`define NSD_SWAP_HI_LSB    8
`define NSD_DEST_BIT       7
`define NSD_LOAD_HI        11'h00c
`define NSD_LOAD_HI_LSB    3
`define NSD_LOAD_SEL_MIN   3'h5
`define NSD_LOAD_SEL_MAX   3'h7

// ---------------------------------------------------------------
// Register space and reset values
// ---------------------------------------------------------------
`define NSD_DIR_ADDR_BASE  7'h45
`define NSD_DIR_COUNT      3
`define NSD_DIR_RESET      8'hff
`define NSD_W_RESET        8'h00

`endif

// [nsd_pkg.sv]
package nsd_pkg;

  // Gray-coded quarter phases of one instruction cycle
  typedef enum logic [1:0] {
    NSD_Q1 = 2'h0,
    NSD_Q2 = 2'h1,
    NSD_Q3 = 2'h3,
    NSD_Q4 = 2'h2
  } nsd_phase_t;

  // Decoded operation held for the current cycle
  typedef enum logic [1:0] {
    NSD_OP_NONE = 2'h0,
    NSD_OP_SWAP = 2'h1,
    NSD_OP_LOAD = 2'h2
  } nsd_op_t;

endpackage

// [nsd_dir_if.sv]
`timescale 1ns/10ps
`default_nettype none

// ---------------------------------------------------------------
// Core to direction bank link
// ---------------------------------------------------------------
interface nsd_dir_if;
  logic [1:0]  rd_idx;
  logic [7:0]  rd_data;
  logic        wr_en;
  logic [1:0]  wr_idx;
  logic [7:0]  wr_data;
  logic [23:0] dir_all;

  modport bank (input rd_idx, input wr_en, input wr_idx, input wr_data,
                output rd_data, output dir_all);
  modport core (output rd_idx, output wr_en, output wr_idx, output wr_data,
                input rd_data, input dir_all);
endinterface

`default_nettype wire

// [nsd_dir_bank.sv]
`timescale 1ns/10ps
`default_nettype none
`include "nsd_defines.svh"

// ---------------------------------------------------------------
// Direction register bank, registered read data
// ---------------------------------------------------------------
module nsd_dir_bank #(
  parameter int COUNT = `NSD_DIR_COUNT
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  nsd_dir_if.bank   dir
);

  logic [7:0] mem_reg [COUNT];
  logic [7:0] rd_reg;

  // Storage; all pins start as inputs
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      for (int i = 0; i < COUNT; i++) begin
        mem_reg[i] <= `NSD_DIR_RESET;
      end
    end else if (dir.wr_en) begin
      mem_reg[dir.wr_idx] <= dir.wr_data;
    end
  end

  // Read data from a flop so the core sees it one phase later
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rd_reg <= `NSD_DIR_RESET;
    end else begin
      rd_reg <= mem_reg[dir.rd_idx];
    end
  end

  assign dir.rd_data = rd_reg;
  assign dir.dir_all = {mem_reg[2], mem_reg[1], mem_reg[0]};

endmodule

`default_nettype wire

// [nsd_core.sv]
`timescale 1ns/10ps
`default_nettype none
`include "nsd_defines.svh"

// Contract
// RULE1: Swap opcode exchanges register nibbles, flags untouched, one instruction cycle.
// RULE2: Swap decodes 7-bit address; destination bit 0 writes W, 1 writes register.
// RULE3: Legacy load copies W into direction register 5 to 7, one cycle.
// RULE4: Direction registers also sit in ordinary register address space.
// RULE5: Software should avoid the legacy load and address direction registers directly.
// RULE6: Swap cycle runs decode, read, process, write in four phases.

module nsd_core (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        instr_valid,
  input  wire logic [13:0] instr,
  input  wire logic [7:0]  reg_rd_data,
  output logic      [1:0]  phase,
  output logic      [6:0]  reg_rd_addr,
  output logic             reg_wr_en,
  output logic      [6:0]  reg_wr_addr,
  output logic      [7:0]  reg_wr_data,
  output logic      [7:0]  w_out,
  output logic      [23:0] dir_out,
  output logic             instr_done
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  nsd_pkg::nsd_phase_t phase_reg;
  nsd_pkg::nsd_phase_t phase_next;
  nsd_pkg::nsd_op_t    op_reg;
  logic [13:0]         instr_reg;
  logic [7:0]          w_reg;
  logic [6:0]          rd_addr_reg;
  logic                wr_en_reg;
  logic [6:0]          wr_addr_reg;
  logic [7:0]          wr_data_reg;
  logic                done_reg;
  logic [23:0]         dir_reg;
  logic                dir_wr_reg;
  logic [1:0]          dir_idx_reg;
  logic [7:0]          dir_data_reg;

  nsd_dir_if dir ();

  nsd_dir_bank #(
    .COUNT(`NSD_DIR_COUNT)
  ) u_bank (
    .clk_sys(clk_sys),
    .rst_n  (rst_n),
    .dir    (dir.bank)
  );

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  wire       is_swap  = instr[`NSD_SWAP_HI_MSB:`NSD_SWAP_HI_LSB] == `NSD_SWAP_HI;
  wire [2:0] load_sel = instr[2:0];
  wire       is_load  = (instr[13:`NSD_LOAD_HI_LSB] == `NSD_LOAD_HI)
                        && (load_sel >= `NSD_LOAD_SEL_MIN);  // [RULE3]
  wire [6:0] f_addr   = instr_reg[6:0];                      // [RULE2]
  wire       dest_reg = instr_reg[`NSD_DEST_BIT];            // [RULE2]
  wire [6:0] dir_off  = f_addr - `NSD_DIR_ADDR_BASE;
  wire       f_is_dir = (f_addr >= `NSD_DIR_ADDR_BASE)
                        && (dir_off < 7'(`NSD_DIR_COUNT));   // [RULE4]
  wire [1:0] ld_idx   = 2'(instr_reg[2:0] - `NSD_LOAD_SEL_MIN);
  wire [7:0] src_data = f_is_dir ? dir.rd_data : reg_rd_data; // [RULE4]
  wire [7:0] swapped  = {src_data[3:0], src_data[7:4]};      // [RULE1]

  // Phase walks Q1..Q4 without stalling; one instruction per lap
  always_comb begin
    case (phase_reg)
      nsd_pkg::NSD_Q1: phase_next = nsd_pkg::NSD_Q2;
      nsd_pkg::NSD_Q2: phase_next = nsd_pkg::NSD_Q3;
      nsd_pkg::NSD_Q3: phase_next = nsd_pkg::NSD_Q4;
      default:         phase_next = nsd_pkg::NSD_Q1;
    endcase
  end

  // ---------------------------------------------------------------
  // Phase and decode (Q1)
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      phase_reg <= nsd_pkg::NSD_Q1;
      op_reg    <= nsd_pkg::NSD_OP_NONE;
      instr_reg <= 14'h0000;
    end else begin
      phase_reg <= phase_next;                               // [RULE6]
      if (phase_reg == nsd_pkg::NSD_Q1) begin
        instr_reg <= instr;
        if (instr_valid && is_swap) begin
          op_reg <= nsd_pkg::NSD_OP_SWAP;                    // [RULE6]
        end else if (instr_valid && is_load) begin
          op_reg <= nsd_pkg::NSD_OP_LOAD;                    // [RULE3]
        end else begin
          op_reg <= nsd_pkg::NSD_OP_NONE;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Read (Q2) and process (Q3)
  // ---------------------------------------------------------------
  // Address is held all cycle; the register file answers half a clock later
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rd_addr_reg <= 7'h00;
    end else if (phase_reg == nsd_pkg::NSD_Q2) begin
      rd_addr_reg <= f_addr;                                 // [RULE6]
    end
  end

  assign dir.rd_idx = dir_off[1:0];

  // ---------------------------------------------------------------
  // Write to destination (end of Q4)
  // ---------------------------------------------------------------
  // Process is combinational over Q3; the swapped value is taken at the Q4 commit
  wire commit    = (phase_reg == nsd_pkg::NSD_Q4);
  wire swap_cmt  = commit && (op_reg == nsd_pkg::NSD_OP_SWAP);
  wire load_cmt  = commit && (op_reg == nsd_pkg::NSD_OP_LOAD);
  wire swap_w    = swap_cmt && !dest_reg;
  wire swap_f    = swap_cmt && dest_reg;
  wire dir_wr    = load_cmt || (swap_f && f_is_dir);         // [RULE3] [RULE4]
  wire [7:0] cmt = swapped;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      w_reg <= `NSD_W_RESET;
    end else if (swap_w) begin
      w_reg <= cmt;                                          // [RULE2]
    end
  end

  // Register file write; direction registers stay inside the bank
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wr_en_reg   <= 1'b0;
      wr_addr_reg <= 7'h00;
      wr_data_reg <= 8'h00;
      done_reg    <= 1'b0;
    end else begin
      wr_en_reg <= swap_f && !f_is_dir;                      // [RULE2]
      done_reg  <= swap_cmt || load_cmt;                     // [RULE1] [RULE3]
      if (swap_f) begin
        wr_addr_reg <= f_addr;
        wr_data_reg <= cmt;
      end
    end
  end

  // Bank write port, registered so both sources share one path
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      dir_wr_reg   <= 1'b0;
      dir_idx_reg  <= 2'h0;
      dir_data_reg <= 8'h00;
      dir_reg      <= {3{`NSD_DIR_RESET}};
    end else begin
      dir_wr_reg   <= dir_wr;
      dir_idx_reg  <= load_cmt ? ld_idx : dir_off[1:0];
      dir_data_reg <= load_cmt ? w_reg : cmt;                // [RULE3]
      dir_reg      <= dir.dir_all;
    end
  end

  assign dir.wr_en   = dir_wr_reg;
  assign dir.wr_idx  = dir_idx_reg;
  assign dir.wr_data = dir_data_reg;

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign phase       = phase_reg;
  assign reg_rd_addr = rd_addr_reg;
  assign reg_wr_en   = wr_en_reg;
  assign reg_wr_addr = wr_addr_reg;
  assign reg_wr_data = wr_data_reg;
  assign w_out       = w_reg;
  assign dir_out     = dir_reg;
  assign instr_done  = done_reg;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_swap_start;
    phase_reg == nsd_pkg::NSD_Q1 && instr_valid && is_swap;
  endsequence

  sequence s_four_phases;
    phase_reg == nsd_pkg::NSD_Q2 ##1 phase_reg == nsd_pkg::NSD_Q3
    ##1 phase_reg == nsd_pkg::NSD_Q4 ##1 phase_reg == nsd_pkg::NSD_Q1;
  endsequence

  property p_swap_phases;
    s_swap_start |=> s_four_phases;
  endproperty
  a_swap_phases: assert property (p_swap_phases) else $error("swap phases out of order"); // [RULE6]

  property p_swap_done;
    s_swap_start |-> ##4 instr_done;
  endproperty
  a_swap_done: assert property (p_swap_done) else $error("swap not done in one cycle"); // [RULE1]

  property p_swap_w;
    swap_w |=> w_reg == {$past(src_data[3:0]), $past(src_data[7:4])};
  endproperty
  a_swap_w: assert property (p_swap_w) else $error("W not swapped value"); // [RULE1]

  property p_swap_f;
    (swap_f && !f_is_dir) |=> reg_wr_en && reg_wr_addr == $past(f_addr)
      && reg_wr_data == {$past(src_data[3:0]), $past(src_data[7:4])}
      && $stable(w_reg);
  endproperty
  a_swap_f: assert property (p_swap_f) else $error("register write wrong"); // [RULE2]

  property p_load;
    load_cmt |-> ##2 u_bank.mem_reg[$past(ld_idx, 2)] == $past(w_reg, 2);
  endproperty
  a_load: assert property (p_load) else $error("direction load wrong"); // [RULE3]

  property p_dir_map;
    (swap_f && f_is_dir) |=> !reg_wr_en && dir_wr_reg ##1
      u_bank.mem_reg[$past(dir_idx_reg)] == $past(dir_data_reg);
  endproperty
  a_dir_map: assert property (p_dir_map) else $error("mapped direction write lost"); // [RULE4]

endmodule

`default_nettype wire

// [test_nibble_swap_and_direction_load.sv]
`timescale 1ns/10ps
`default_nettype none

module test_nibble_swap_and_direction_load;
  logic        clk_sys     = 1'b0;
  logic        rst_n       = 1'b0;
  logic        instr_valid = 1'b0;
  logic [13:0] instr       = 14'h0000;
  logic [7:0]  reg_rd_data = 8'h00;
  logic [1:0]  phase;
  logic [6:0]  reg_rd_addr;
  logic        reg_wr_en;
  logic [6:0]  reg_wr_addr;
  logic [7:0]  reg_wr_data;
  logic [7:0]  w_out;
  logic [23:0] dir_out;
  logic        instr_done;
  logic [7:0]  mem [128];
  logic [7:0]  mem_exp [128];
  logic [7:0]  dir_exp [3];
  logic [7:0]  w_exp;
  int          n_fail   = 0;
  int          n_checks = 0;
  integer      seed     = 35;

  nsd_core dut (.clk_sys(clk_sys), .rst_n(rst_n), .instr_valid(instr_valid), .instr(instr),
    .reg_rd_data(reg_rd_data), .phase(phase), .reg_rd_addr(reg_rd_addr),
    .reg_wr_en(reg_wr_en), .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data),
    .w_out(w_out), .dir_out(dir_out), .instr_done(instr_done));

  // 50 MHz clock
  always #10 clk_sys = ~clk_sys;

  // Register file stand-in, half a clock of read latency
  always @(negedge clk_sys) reg_rd_data <= mem[reg_rd_addr];
  always @(posedge clk_sys) if (reg_wr_en === 1'b1) mem[reg_wr_addr] <= reg_wr_data;

  // ---------------------------------------------------------------
  // Checking helpers
  // ---------------------------------------------------------------
  task automatic conclude;
    if (n_fail == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  function automatic logic [7:0] swp(input logic [7:0] v);
    return {v[3:0], v[7:4]};
  endfunction

  function automatic logic is_dir(input logic [6:0] f);
    return f >= 7'h45 && f <= 7'h47;
  endfunction

  // ---------------------------------------------------------------
  // Instruction drivers
  // ---------------------------------------------------------------
  // Present in Q1, drop after the taking edge, look just after the commit edge
  task automatic exec(input logic [13:0] ins, input logic done_exp);
    while (phase !== nsd_pkg::NSD_Q1) @(negedge clk_sys);
    instr_valid = 1'b1;
    instr       = ins;
    @(posedge clk_sys);
    @(negedge clk_sys);
    instr_valid = 1'b0;
    instr       = 14'($random(seed));
    check("phase", phase, nsd_pkg::NSD_Q2);
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    check("instr_done", instr_done, done_exp);
    check("phase", phase, nsd_pkg::NSD_Q1);
  endtask

  // Bank updates land one clock after the commit and show on dir_out two clocks after it
  task automatic check_dir;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    check("dir_out", dir_out, {dir_exp[2], dir_exp[1], dir_exp[0]});
  endtask

  task automatic do_swap(input logic [6:0] f, input logic d);
    logic [7:0] r;
    r = swp(is_dir(f) ? dir_exp[f - 7'h45] : mem_exp[f]);
    exec({6'h0e, d, f}, 1'b1);
    check("reg_rd_addr", reg_rd_addr, f);
    if (!d) w_exp = r;
    check("w_out", w_out, w_exp);
    check("reg_wr_en", reg_wr_en, d && !is_dir(f));
    if (d && !is_dir(f)) begin
      check("reg_wr_addr", reg_wr_addr, f);
      check("reg_wr_data", reg_wr_data, r);
      mem_exp[f] = r;
    end
    if (d && is_dir(f)) begin
      dir_exp[f - 7'h45] = r;
      check_dir();
    end
  endtask

  // Valid held only through Q2 to Q4 must be ignored
  task automatic stray;
    while (phase !== nsd_pkg::NSD_Q2) @(negedge clk_sys);
    instr_valid = 1'b1;
    instr       = {6'h0e, 1'b0, 7'h11};
    repeat (3) begin
      @(posedge clk_sys);
      @(negedge clk_sys);
    end
    instr_valid = 1'b0;
    repeat (6) begin
      @(posedge clk_sys);
      @(negedge clk_sys);
      check("instr_done", instr_done, 1'b0);
    end
    check("w_out", w_out, w_exp);
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    for (int i = 0; i < 128; i++) mem[i] = 8'($random(seed));
    mem[7'h11] = 8'ha5;
    mem_exp = mem;
    foreach (dir_exp[i]) dir_exp[i] = 8'hff;
    w_exp = 8'h00;
    repeat (10) @(posedge clk_sys);
    @(negedge clk_sys);
    rst_n = 1'b1;
    check("w_out", w_out, 8'h00);
    check("dir_out", dir_out, 24'hffffff);
    check("instr_done", instr_done, 1'b0);
    do_swap(7'h11, 1'b0);
    // Every selector value, reserved ones included
    for (int s = 0; s < 8; s++) begin
      do_swap(7'($random(seed)) & 7'h3f, 1'b0);
      exec({11'h00c, 3'(s)}, s >= 5);
      if (s >= 5) dir_exp[s - 5] = w_exp;
      check("w_out", w_out, w_exp);
    end
    check_dir();
    for (int a = 5; a < 8; a++) do_swap(7'h40 + 7'(a), 1'b1);
    do_swap(7'h46, 1'b0);
    stray();
    do_swap(7'h7f, 1'b1);
    do_swap(7'h00, 1'b1);
    // Back-to-back random traffic
    repeat (40) do_swap(7'($random(seed)), 1'($random(seed)));
    conclude();
  end

  // Watchdog well past the expected run length
  initial begin
    #400000;
    n_fail++;
    conclude();
  end
endmodule

`default_nettype wire
